/* pdmc_pkg.sv */
// pdmc_pkg: shared constants and types for the power-down mode controller
// assumes: used by pdmc_top, pdmc_settle, pdmc_ahb and pdmc_tb
package pdmc_pkg;
  // register byte addresses (printed offsets, not word aligned -> index*4)
  localparam logic [15:0] CTRL_ONE_IDX = 16'hFFF0;
  localparam logic [15:0] CTRL_TWO_IDX = 16'hFFF1;
  localparam logic [17:0] CTRL_ONE_ADDR = {CTRL_ONE_IDX, 2'h0};
  localparam logic [17:0] CTRL_TWO_ADDR = {CTRL_TWO_IDX, 2'h0};
  // reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'hF4;
  // field positions, register one
  localparam int STBY_BIT  = 7;
  localparam int STS_LSB   = 4;
  localparam int LOW_SPEED_SELECT_BIT  = 3;
  localparam int RSV2_BIT  = 2;
  // field positions, register two
  localparam int DWAKE_BIT = 3;
  localparam logic [7:0] CTRL_TWO_FIXED = 8'hF4;
  localparam logic [7:0] CTRL_TWO_LOW_MASK = 8'h03;
  // settling waits in states
  localparam logic [17:0] SETTLE_0 = 18'h02000;
  localparam logic [17:0] SETTLE_1 = 18'h04000;
  localparam logic [17:0] SETTLE_2 = 18'h08000;
  localparam logic [17:0] SETTLE_3 = 18'h10000;
  localparam logic [17:0] SETTLE_4 = 18'h20000;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    PDMC_ACTIVE,
    PDMC_SLEEP,
    PDMC_STANDBY,
    PDMC_WATCH,
    PDMC_SUBACT,
    PDMC_SETTLE,
    PDMC_RESET
  } pdmc_mode_e;
endpackage

/* pdmc_settle.sv */
// pdmc_settle: oscillator settling-wait counter
// assumes: start pulse from the mode machine; runs on the system clock
`timescale 1ns/1ps
module pdmc_settle
#(
  parameter int SCALE_SHIFT = 0
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // control
  input  wire logic        start,
  input  wire logic [2:0]  sel,
  // status
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        busy;
    logic        done;
  } pdmc_settle_s;

  pdmc_settle_s st_r;
  pdmc_settle_s st_nxt;

  // shift lets a simulation shorten the waits
  // field to wait length
  function automatic logic [17:0] settle_len(input logic [2:0] s);
    logic [17:0] v;
    v = pdmc_pkg::SETTLE_4;
    if (s == 3'h0)
      v = pdmc_pkg::SETTLE_0;
    else if (s == 3'h1)
      v = pdmc_pkg::SETTLE_1;
    else if (s == 3'h2)
      v = pdmc_pkg::SETTLE_2;
    else if (s == 3'h3)
      v = pdmc_pkg::SETTLE_3;
    settle_len = v >> SCALE_SHIFT;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start)
    begin
      st_nxt.cnt = settle_len(sel) - 18'h00001;
      st_nxt.busy = 1'b1;
    end
    else if (st_r.busy)
    begin
      if (st_r.cnt == 18'h00000)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
      else
        st_nxt.cnt = st_r.cnt - 18'h00001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

  // assertion helper: cycles spent busy since the last start, and the
  // length that the selection asks for, worked out by doubling
  logic [17:0] ast_cnt_r;
  logic [17:0] ast_len_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ast_cnt_r <= 18'h00000;
      ast_len_r <= 18'h00000;
    end
    else if (start)
    begin
      ast_cnt_r <= 18'h00000;
      ast_len_r <= (pdmc_pkg::SETTLE_0 << (sel[2] ? 3'h4 : {1'b0, sel[1:0]}))
        >> SCALE_SHIFT;
    end
    else if (st_r.busy)
      ast_cnt_r <= ast_cnt_r + 18'h00001;
  end

  AST_SETTLE_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    done |-> ast_cnt_r == ast_len_r)
    else $error("settle wait length wrong");
endmodule

/* pdmc_ahb.sv */
// pdmc_ahb: ahb-lite slave front end, single word transfers
// assumes: one master; writes act in the data phase, reads decode early
`timescale 1ns/1ps
module pdmc_ahb
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  // decoded writes in the data phase, reads in the address phase
  output logic             wr_one,
  output logic             wr_two,
  output logic             rd_one,
  output logic             rd_two
);
  typedef struct packed {
    logic w1;
    logic w2;
  } pdmc_ahb_s;

  pdmc_ahb_s st_r;
  pdmc_ahb_s st_nxt;
  logic      take;
  logic      hit_one;
  logic      hit_two;

  always_comb
  begin
    st_nxt = '0;
    take = hsel && hready && htrans == pdmc_pkg::HTRANS_NONSEQ;
    hit_one = 1'b0;
    hit_two = 1'b0;
    if (take && haddr[17:0] == pdmc_pkg::CTRL_ONE_ADDR)
      hit_one = 1'b1;
    else if (take && haddr[17:0] == pdmc_pkg::CTRL_TWO_ADDR)
      hit_two = 1'b1;
    // writes wait for hwdata, which only stands in the data phase
    st_nxt.w1 = hit_one && hwrite;
    st_nxt.w2 = hit_two && hwrite;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign wr_one = st_r.w1;
  assign wr_two = st_r.w2;
  // reads decode in the address phase so hrdata is loaded at its end and
  // stands through the data phase
  assign rd_one = hit_one && !hwrite;
  assign rd_two = hit_two && !hwrite;
endmodule

/* pdmc_top.sv */
// pdmc_top: power-down mode sequencer with its two control registers
// assumes: cpu pulses sleep_exec; wake and reset pins are asynchronous
`timescale 1ns/1ps
module pdmc_top
#(
  parameter int SCALE_SHIFT = 0
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hsize,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // cpu and interrupt controller
  input  wire logic        sleep_exec,
  input  wire logic        cpu_int_mask,
  input  wire logic        timer_a_watch_select,
  input  wire logic        wake_irq_zero_en,
  input  wire logic        wake_irq_one_en,
  input  wire logic        tmra_en,
  input  wire logic        dxfer_en,
  input  wire logic        timer_a_ovf,
  // pins
  input  wire logic        reset_input_n,
  input  wire logic        wake_irq_zero,
  input  wire logic        wake_irq_one,
  // mode outputs
  output logic [2:0]       mode,
  output logic             osc_run,
  output logic             sys_clk_gate,
  output logic             cpu_on_subclk,
  output logic             periph_halt,
  output logic             port_release,
  output logic             timer_a_subclk,
  output logic             irq_start,
  output logic             dxfer_irq,
  output logic             cpu_reset_n
);
  typedef struct packed {
    logic [2:0]  pin0;
    logic [2:0]  pin1;
    logic [2:0]  pinr;
    logic        w0;
    logic        w1;
    logic        rn;
    logic        stby;
    logic [2:0]  sts;
    logic        low_speed_select;
    logic        rsv2;
    logic        dwake;
    logic [1:0]  low2;
    pdmc_pkg::pdmc_mode_e md;
    logic        to_sub;
    logic        settle_go;
    logic [31:0] rdata;
    logic        irq_start;
    logic        dxfer_irq;
    logic        cpu_rst_n;
    logic        osc;
    logic        gate;
    logic        subclk;
    logic        halt;
    logic        rel;
    logic        tsub;
  } pdmc_top_s;

  pdmc_top_s st_r;
  pdmc_top_s st_nxt;
  logic wr_one;
  logic wr_two;
  logic rd_one;
  logic rd_two;
  logic settle_busy;
  logic settle_done;
  logic wake_w_chk;

  pdmc_ahb u_ahb
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .wr_one  (wr_one),
    .wr_two  (wr_two),
    .rd_one  (rd_one),
    .rd_two  (rd_two)
  );

  pdmc_settle #(.SCALE_SHIFT(SCALE_SHIFT)) u_settle
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (st_r.settle_go),
    .sel     (st_r.sts),
    .busy    (settle_busy),
    .done    (settle_done)
  );

  function automatic logic [7:0] reg_one(input pdmc_top_s s);
    reg_one = {s.stby, s.sts, s.low_speed_select, s.rsv2, 2'h0};
  endfunction

  function automatic logic [7:0] reg_two(input pdmc_top_s s);
    reg_two = pdmc_pkg::CTRL_TWO_FIXED & ~pdmc_pkg::CTRL_TWO_LOW_MASK;
    reg_two[pdmc_pkg::DWAKE_BIT] = s.dwake;
    reg_two[1:0] = s.low2;
  endfunction

  always_comb
  begin
    logic wake01;
    logic wake_w;
    logic rst_lo;
    wake01 = !cpu_int_mask && ((st_r.w0 && wake_irq_zero_en) || (st_r.w1 && wake_irq_one_en));
    wake_w = !cpu_int_mask
      && ((st_r.w0 && wake_irq_zero_en) || (timer_a_ovf && tmra_en));
    rst_lo = !st_r.rn;
    st_nxt = st_r;
    // three-stage pin capture; change counts when stages two and three agree
    st_nxt.pin0 = {st_r.pin0[1:0], wake_irq_zero};
    st_nxt.pin1 = {st_r.pin1[1:0], wake_irq_one};
    st_nxt.pinr = {st_r.pinr[1:0], reset_input_n};
    if (st_r.pin0[1] == st_r.pin0[2])
      st_nxt.w0 = st_r.pin0[2];
    if (st_r.pin1[1] == st_r.pin1[2])
      st_nxt.w1 = st_r.pin1[2];
    if (st_r.pinr[1] == st_r.pinr[2])
      st_nxt.rn = st_r.pinr[2];
    st_nxt.irq_start = 1'b0;
    st_nxt.dxfer_irq = 1'b0;
    st_nxt.settle_go = 1'b0;
    st_nxt.rdata = 32'h00000000;

    // register writes
    if (wr_one)
    begin
      if (st_r.md == pdmc_pkg::PDMC_ACTIVE)
        st_nxt.stby = hwdata[pdmc_pkg::STBY_BIT];
      st_nxt.sts = hwdata[pdmc_pkg::STS_LSB +: 3];
      st_nxt.low_speed_select = hwdata[pdmc_pkg::LOW_SPEED_SELECT_BIT];
      // bit 2 kept, bits 1 and 0 dropped
      st_nxt.rsv2 = hwdata[pdmc_pkg::RSV2_BIT];
    end
    if (wr_two)
    begin
      if (st_r.md == pdmc_pkg::PDMC_SUBACT)
        st_nxt.dwake = hwdata[pdmc_pkg::DWAKE_BIT];
      st_nxt.low2 = hwdata[1:0];
    end
    // read from the updated copy so a write still in its data phase is seen
    if (rd_one)
      st_nxt.rdata = {24'h000000, reg_one(st_nxt)};
    else if (rd_two)
      st_nxt.rdata = {24'h000000, reg_two(st_nxt)};

    // reset input first, one transition per event
    if (rst_lo && st_r.md != pdmc_pkg::PDMC_ACTIVE)
    begin
      // reset ends low-power mode, oscillator runs
      st_nxt.md = pdmc_pkg::PDMC_RESET;
      st_nxt.cpu_rst_n = 1'b0;
    end
    else if (rst_lo)
    begin
      st_nxt.md = pdmc_pkg::PDMC_RESET;
      st_nxt.cpu_rst_n = 1'b0;
    end
    else
    begin
      case (st_r.md)
        pdmc_pkg::PDMC_ACTIVE:
        begin
          if (sleep_exec)
          begin
            if (!st_r.stby)
              st_nxt.md = pdmc_pkg::PDMC_SLEEP;
            else if (timer_a_watch_select)
              st_nxt.md = pdmc_pkg::PDMC_WATCH;
            else
              st_nxt.md = pdmc_pkg::PDMC_STANDBY;
          end
        end
        pdmc_pkg::PDMC_SLEEP:
        begin
          // enabled wake zero, one or timer
          if (wake01 || (!cpu_int_mask && timer_a_ovf && tmra_en))
          begin
            st_nxt.md = pdmc_pkg::PDMC_ACTIVE;
            st_nxt.irq_start = 1'b1;
          end
        end
        pdmc_pkg::PDMC_STANDBY:
        begin
          if (wake01)
          begin
            st_nxt.md = pdmc_pkg::PDMC_SETTLE;
            st_nxt.to_sub = 1'b0;
            st_nxt.settle_go = 1'b1;
          end
        end
        pdmc_pkg::PDMC_WATCH:
        begin
          if (wake_w)
          begin
            if (st_r.low_speed_select)
            begin
              st_nxt.md = pdmc_pkg::PDMC_SUBACT;
              st_nxt.irq_start = 1'b1;
            end
            else
            begin
              st_nxt.md = pdmc_pkg::PDMC_SETTLE;
              st_nxt.settle_go = 1'b1;
            end
          end
        end
        pdmc_pkg::PDMC_SUBACT:
        begin
          if (sleep_exec)
          begin
            if (st_r.dwake && !st_r.low_speed_select && !cpu_int_mask && dxfer_en)
            begin
              st_nxt.md = pdmc_pkg::PDMC_SETTLE;
              st_nxt.dxfer_irq = 1'b1;
              st_nxt.settle_go = 1'b1;
            end
            else if (!st_r.dwake)
              st_nxt.md = pdmc_pkg::PDMC_WATCH;
          end
        end
        pdmc_pkg::PDMC_SETTLE:
        begin
          if (settle_done)
          begin
            st_nxt.md = pdmc_pkg::PDMC_ACTIVE;
            st_nxt.irq_start = 1'b1;
          end
        end
        pdmc_pkg::PDMC_RESET:
        begin
          // cpu leaves reset only when pin returns high
          st_nxt.md = pdmc_pkg::PDMC_ACTIVE;
          st_nxt.cpu_rst_n = 1'b1;
          st_nxt.stby = pdmc_pkg::CTRL_ONE_RST[pdmc_pkg::STBY_BIT];
          st_nxt.sts = pdmc_pkg::CTRL_ONE_RST[pdmc_pkg::STS_LSB +: 3];
          st_nxt.low_speed_select = pdmc_pkg::CTRL_ONE_RST[pdmc_pkg::LOW_SPEED_SELECT_BIT];
          st_nxt.rsv2 = pdmc_pkg::CTRL_ONE_RST[pdmc_pkg::RSV2_BIT];
          st_nxt.dwake = pdmc_pkg::CTRL_TWO_RST[pdmc_pkg::DWAKE_BIT];
          st_nxt.low2 = pdmc_pkg::CTRL_TWO_RST[1:0];
        end
        default:
          st_nxt.md = pdmc_pkg::PDMC_ACTIVE;
      endcase
    end

    // clock and peripheral controls from next mode
    st_nxt.osc = !(st_nxt.md == pdmc_pkg::PDMC_STANDBY
      || st_nxt.md == pdmc_pkg::PDMC_WATCH
      || st_nxt.md == pdmc_pkg::PDMC_SUBACT);
    st_nxt.gate = st_nxt.md == pdmc_pkg::PDMC_ACTIVE
      || st_nxt.md == pdmc_pkg::PDMC_SLEEP
      || st_nxt.md == pdmc_pkg::PDMC_RESET;
    st_nxt.subclk = st_nxt.md == pdmc_pkg::PDMC_SUBACT;
    st_nxt.halt = !(st_nxt.md == pdmc_pkg::PDMC_ACTIVE
      || st_nxt.md == pdmc_pkg::PDMC_SLEEP);
    st_nxt.rel = st_nxt.md == pdmc_pkg::PDMC_STANDBY
      || st_nxt.md == pdmc_pkg::PDMC_WATCH
      || st_nxt.md == pdmc_pkg::PDMC_SUBACT;
    st_nxt.tsub = st_nxt.md == pdmc_pkg::PDMC_WATCH
      || st_nxt.md == pdmc_pkg::PDMC_SUBACT;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '0;
      st_r.pin0 <= 3'h0;
      st_r.pinr <= 3'h7;
      st_r.rn <= 1'b1;
      st_r.dwake <= 1'b0;
      st_r.md <= pdmc_pkg::PDMC_ACTIVE;
      st_r.cpu_rst_n <= 1'b1;
      st_r.osc <= 1'b1;
      st_r.gate <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign hrdata = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mode = st_r.md;
  assign osc_run = st_r.osc;
  assign sys_clk_gate = st_r.gate;
  assign cpu_on_subclk = st_r.subclk;
  assign periph_halt = st_r.halt;
  assign port_release = st_r.rel;
  assign timer_a_subclk = st_r.tsub;
  assign irq_start = st_r.irq_start;
  assign dxfer_irq = st_r.dxfer_irq;
  assign cpu_reset_n = st_r.cpu_rst_n;

  AST_SLEEP_STBY: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.md == pdmc_pkg::PDMC_ACTIVE && sleep_exec && st_r.rn
     && st_r.stby && !timer_a_watch_select)
    |=> st_r.md == pdmc_pkg::PDMC_STANDBY)
    else $error("standby not entered");
  AST_SLEEP_WATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.md == pdmc_pkg::PDMC_ACTIVE && sleep_exec && st_r.rn
     && st_r.stby && timer_a_watch_select)
    |=> st_r.md == pdmc_pkg::PDMC_WATCH)
    else $error("watch not entered");
  AST_STBY_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.md == pdmc_pkg::PDMC_STANDBY && cpu_int_mask && st_r.rn)
    |=> st_r.md == pdmc_pkg::PDMC_STANDBY)
    else $error("standby left while masked");
  AST_WATCH_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.md == pdmc_pkg::PDMC_WATCH && cpu_int_mask && st_r.rn)
    |=> st_r.md == pdmc_pkg::PDMC_WATCH)
    else $error("watch left while masked");
  AST_WATCH_SUB: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.md == pdmc_pkg::PDMC_WATCH && wake_w_chk && st_r.low_speed_select
     && st_r.rn) |=> st_r.md == pdmc_pkg::PDMC_SUBACT)
    else $error("subactive not entered");
  AST_NO_DIRECT_LS: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_r.md == pdmc_pkg::PDMC_SUBACT && st_r.low_speed_select) |=> !st_r.dxfer_irq)
    else $error("direct transfer with low speed set");
  AST_RESET_PRIO: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_r.rn && st_r.md != pdmc_pkg::PDMC_ACTIVE)
    |=> st_r.md == pdmc_pkg::PDMC_RESET && st_r.osc)
    else $error("reset input ignored");
  AST_WATCH_OSC: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.md == pdmc_pkg::PDMC_WATCH |-> !st_r.osc && st_r.halt
    && st_r.tsub)
    else $error("watch clocks wrong");
  AST_SETTLE_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r.md == pdmc_pkg::PDMC_SETTLE
    |-> st_r.settle_go || settle_busy || settle_done)
    else $error("settle counter not running");

  assign wake_w_chk = !cpu_int_mask
    && ((st_r.w0 && wake_irq_zero_en) || (timer_a_ovf && tmra_en));
endmodule

/* pdmc_cpu_model.sv */
// pdmc_cpu_model: cpu core and reset source as seen by the block
// assumes: the bench asks for sleep and reset; osc_run comes from the block
`timescale 1ns/1ps
module pdmc_cpu_model
#(
  parameter int STABLE = 64
)
(
  // clock
  input  wire logic hclk,
  // bench requests
  input  wire logic sleep_req,
  input  wire logic pin_low_req,
  // from the block
  input  wire logic osc_run,
  // to the block
  output logic      sleep_exec,
  output logic      reset_input_n
);
  int unsigned run_cnt;

  initial
  begin
    sleep_exec = 1'b0;
    reset_input_n = 1'b1;
    run_cnt = 0;
  end

  // one sleep instruction per request, a single cycle long
  always @(posedge hclk)
    sleep_exec <= sleep_req;

  // pin held low
  // a slow source: the pin waits until the clock has run STABLE cycles
  always @(posedge hclk)
  begin
    run_cnt <= osc_run ? run_cnt + 1 : 0;
    if (pin_low_req)
      reset_input_n <= 1'b0;
    else if (run_cnt >= STABLE)
      reset_input_n <= 1'b1;
  end
endmodule

/* pdmc_tb.sv */
// pdmc_tb: register and mode sequence tests for pdmc_top
// assumes: pdmc_cpu_model stands in for the cpu and the reset source
`timescale 1ns/1ps
module pdmc_tb;
  localparam logic [31:0] ADR1 = {14'h0, pdmc_pkg::CTRL_ONE_ADDR};
  localparam logic [31:0] ADR2 = {14'h0, pdmc_pkg::CTRL_TWO_ADDR};
  // settle waits shrink by 2**SHIFT to keep the run short
  localparam int SHIFT = 6;
  logic hclk, hresetn, hsel, hwrite, hresp, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic sleep_req, pin_low_req, sleep_exec, reset_input_n;
  logic cpu_int_mask, timer_a_watch_select, timer_a_ovf;
  logic wake_irq_zero_en, wake_irq_one_en, tmra_en, dxfer_en;
  logic wake_irq_zero, wake_irq_one, osc_run, sys_clk_gate;
  logic cpu_on_subclk, periph_halt, port_release, timer_a_subclk;
  logic irq_start, dxfer_irq, cpu_reset_n, dx_seen;
  logic [2:0] mode;
  int num_errors, n_checks, cyc;

  pdmc_top #(.SCALE_SHIFT(SHIFT)) pdmc_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hsize(pdmc_pkg::HSIZE_WORD), .hwrite(hwrite),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_exec(sleep_exec),
    .cpu_int_mask(cpu_int_mask),
    .timer_a_watch_select(timer_a_watch_select), .wake_irq_zero_en(wake_irq_zero_en),
    .wake_irq_one_en(wake_irq_one_en), .tmra_en(tmra_en), .dxfer_en(dxfer_en),
    .timer_a_ovf(timer_a_ovf), .reset_input_n(reset_input_n),
    .wake_irq_zero(wake_irq_zero), .wake_irq_one(wake_irq_one),
    .mode(mode), .osc_run(osc_run), .sys_clk_gate(sys_clk_gate),
    .cpu_on_subclk(cpu_on_subclk), .periph_halt(periph_halt),
    .port_release(port_release), .timer_a_subclk(timer_a_subclk),
    .irq_start(irq_start), .dxfer_irq(dxfer_irq),
    .cpu_reset_n(cpu_reset_n));

  pdmc_cpu_model #(.STABLE(64)) pdmc_cpu_model_i (
    .hclk(hclk), .sleep_req(sleep_req), .pin_low_req(pin_low_req),
    .osc_run(osc_run), .sleep_exec(sleep_exec),
    .reset_input_n(reset_input_n));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  always @(posedge hclk)
    if (dxfer_irq === 1'b1)
      dx_seen <= 1'b1;

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // one single transfer; hready is sampled at each edge before moving on
  task automatic ahb(input logic [31:0] a, input logic w,
                     input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= pdmc_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    ahb(a, 1'b0, 8'h00);
    chk("hrdata", {24'h0, e}, rd);
  endtask

  task automatic wait_mode(input logic [2:0] m, input int lim);
    cyc = 0;
    while (mode !== m && cyc < lim)
    begin
      @(posedge hclk);
      cyc++;
    end
    chk("mode", {29'h0, m}, {29'h0, mode});
  endtask

  // cycles from the wake request to the interrupt start pulse
  task automatic wait_irq(input int s);
    int n;
    n = (8192 << (s > 3 ? 4 : s)) >> SHIFT;
    cyc = 0;
    while (irq_start !== 1'b1 && cyc < n + 40)
    begin
      @(posedge hclk);
      cyc++;
    end
    chk("settle span", 32'h1, {31'h0, cyc >= n && cyc <= n + 16});
  endtask

  task automatic sleep_cmd();
    sleep_req <= 1'b1;
    @(posedge hclk);
    sleep_req <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  initial
  begin
    #(20000 * 50);
    num_errors++;
    complete_run();
  end

  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {sleep_req, pin_low_req, cpu_int_mask, timer_a_watch_select} = '0;
    {timer_a_ovf, wake_irq_zero_en, wake_irq_one_en, tmra_en, dxfer_en} = '0;
    {wake_irq_zero, wake_irq_one, dx_seen} = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADR1, 8'h00);
    rd_chk(ADR2, 8'hF4);
    rd_chk(32'h100, 8'h00);
    ahb(ADR1, 1'b1, 8'hFF);
    rd_chk(ADR1, 8'hFC);
    ahb(ADR2, 1'b1, 8'h08);
    rd_chk(ADR2, 8'hF4);
    ahb(ADR1, 1'b1, 8'h04);
    sleep_cmd();
    wait_mode(pdmc_pkg::PDMC_SLEEP, 4);
    {wake_irq_zero_en, wake_irq_one_en, tmra_en} <= 3'h7;
    wake_irq_zero <= 1'b1;
    wait_mode(pdmc_pkg::PDMC_ACTIVE, 20);
    wake_irq_zero <= 1'b0;
    ahb(ADR1, 1'b1, 8'h80);
    sleep_cmd();
    wait_mode(pdmc_pkg::PDMC_STANDBY, 4);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    cpu_int_mask <= 1'b1;
    wake_irq_one <= 1'b1;
    repeat (20) @(posedge hclk);
    wait_mode(pdmc_pkg::PDMC_STANDBY, 0);
    cpu_int_mask <= 1'b0;
    wait_irq(0);
    wake_irq_one <= 1'b0;
    rd_chk(ADR1, 8'h80);
    // longest field value exercises the top of the wait table
    ahb(ADR1, 1'b1, 8'hC0);
    timer_a_watch_select <= 1'b1;
    sleep_cmd();
    wait_mode(pdmc_pkg::PDMC_WATCH, 4);
    chk("halted", 32'h3, {29'h0, osc_run, periph_halt, timer_a_subclk});
    tmra_en <= 1'b0;
    timer_a_ovf <= 1'b1;
    repeat (20) @(posedge hclk);
    wait_mode(pdmc_pkg::PDMC_WATCH, 0);
    tmra_en <= 1'b1;
    wait_irq(4);
    timer_a_ovf <= 1'b0;
    ahb(ADR1, 1'b1, 8'h88);
    sleep_cmd();
    wake_irq_zero <= 1'b1;
    wait_mode(pdmc_pkg::PDMC_SUBACT, 20);
    wake_irq_zero <= 1'b0;
    // let the pin capture stages drain, or watch is left again at once
    repeat (5) @(posedge hclk);
    chk("sub", 32'h7, {29'h0, cpu_on_subclk, periph_halt, port_release});
    sleep_cmd();
    wait_mode(pdmc_pkg::PDMC_WATCH, 4);
    chk("tmr_sub", 32'h1, {31'h0, timer_a_subclk});
    timer_a_ovf <= 1'b1;
    wait_mode(pdmc_pkg::PDMC_SUBACT, 20);
    timer_a_ovf <= 1'b0;
    ahb(ADR2, 1'b1, 8'h08);
    rd_chk(ADR2, 8'hFC);
    ahb(ADR1, 1'b1, 8'h00);
    rd_chk(ADR1, 8'h80);
    dxfer_en <= 1'b1;
    sleep_cmd();
    wait_mode(pdmc_pkg::PDMC_ACTIVE, 200);
    chk("dxfer", 32'h1, {31'h0, dx_seen});
    ahb(ADR1, 1'b1, 8'h88);
    sleep_cmd();
    timer_a_ovf <= 1'b1;
    wait_mode(pdmc_pkg::PDMC_SUBACT, 20);
    timer_a_ovf <= 1'b0;
    ahb(ADR1, 1'b1, 8'h80);
    cpu_int_mask <= 1'b1;
    dx_seen <= 1'b0;
    sleep_cmd();
    repeat (200) @(posedge hclk);
    chk("no dxfer", 32'h0, {31'h0, dx_seen});
    chk("active", 32'h0, {31'h0, mode === pdmc_pkg::PDMC_ACTIVE});
    cpu_int_mask <= 1'b0;
    pin_low_req <= 1'b1;
    wait_mode(pdmc_pkg::PDMC_RESET, 20);
    chk("pin low", 32'h1, {30'h0, cpu_reset_n, osc_run});
    pin_low_req <= 1'b0;
    wait_mode(pdmc_pkg::PDMC_ACTIVE, 400);
    chk("cpu_reset_n", 32'h1, {31'h0, cpu_reset_n});
    rd_chk(ADR1, 8'h00);
    rd_chk(ADR2, 8'hF4);
    complete_run();
  end
endmodule
